// ===== sram_like_host_bus_port.sv
// Host bus port: strobe-framed reads and writes to registers and data FIFOs.
// Assumes strobes, address and data pins are synchronous to clk_in.
`timescale 1ns/1ps
// Notes on behaviour
// - Reads reach registers, FIFOs; counters latched
// - Read starts both low, ends either high
// - Burst reads follow address, up to sixteen
// - Direct select read returns receive FIFO
// - Direct mode decodes A[2:1], ignores A[7:3]
// - Direct select timed like an address
// - Direct burst reads are unlimited
// - Write starts both low, ends either high
// - Direct select write pushes transmit FIFO
module sram_like_host_bus_port
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Host strobes and address
  input wire logic host_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic fifo_sel_in,
  // Host data bus
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  // Receive data FIFO
  input wire logic [DATA_W-1:0] rx_data_in,
  output logic rx_data_pop_out,
  // Status FIFOs
  input wire logic [DATA_W-1:0] rx_status_in,
  output logic rx_status_pop_out,
  input wire logic [DATA_W-1:0] tx_status_in,
  output logic tx_status_pop_out,
  // Level and counter values
  input wire logic [DATA_W-1:0] rx_fifo_level_info_in,
  input wire logic [DATA_W-1:0] tx_fifo_level_info_in,
  input wire logic [DATA_W-1:0] drop_count_in,
  // Transmit data FIFO push
  output logic [DATA_W-1:0] tx_data_out,
  output logic tx_data_valid_out,
  input wire logic tx_data_ready_in,
  // Register writes and FIFO lane
  output logic [ADDR_W-1:0] reg_wr_addr_out,
  output logic [DATA_W-1:0] reg_wr_data_out,
  output logic reg_wr_out,
  output logic [SEL_W-1:0] fifo_lane_out
);
  // =========================================
  // Cycle framing
  cyc_t cyc_q;
  cyc_t cyc_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic wsel_q;
  logic [4:0] burst_cnt_q;
  logic [DATA_W-1:0] count_hold_q;
  logic [DATA_W-1:0] data_q;
  logic oe_q;
  logic rx_pop_q;
  logic rxs_pop_q;
  logic txs_pop_q;
  logic reg_wr_q;
  logic [ADDR_W-1:0] reg_addr_q;
  logic [DATA_W-1:0] reg_data_q;
  logic [SEL_W-1:0] lane_q;
  logic buf_valid;

  wire rd_active = !host_select_n_in && !read_strobe_n_in;
  wire wr_active = !host_select_n_in && !write_strobe_n_in;
  wire rd_start = (cyc_q == CYC_IDLE) && rd_active;
  wire wr_start = (cyc_q == CYC_IDLE) && wr_active && !rd_active;
  wire rd_end = (cyc_q == CYC_READ) && !rd_active;
  wire wr_end = (cyc_q == CYC_WRITE) && !wr_active;
  wire addr_step = (cyc_q == CYC_READ) && rd_active && (addr_in != addr_q);
  // Direct mode keeps only the lane bits
  wire [ADDR_W-1:0] eff_addr = fifo_sel_in ? {5'h00, addr_in[1:0]} : addr_in;
  wire read_take = rd_start || addr_step;
  // Ordinary bursts stop following the address past sixteen words
  wire burst_ok = fifo_sel_in || (burst_cnt_q < BURST_MAX);
  wire hit_rx = fifo_sel_in || (addr_in == ADDR_RX_DATA);
  wire hit_rxs = !fifo_sel_in && (addr_in == ADDR_RX_STATUS);
  wire hit_txs = !fifo_sel_in && (addr_in == ADDR_TX_STATUS);
  wire hit_cnt = !fifo_sel_in && (addr_in == ADDR_DROP_CNT);
  wire do_read = read_take && burst_ok;
  // Counter snapshot from the start of the read cycle
  wire [DATA_W-1:0] cnt_word = (cyc_q == CYC_READ) ? count_hold_q : drop_count_in;
  logic [DATA_W-1:0] rd_word;

  // Read selection
  always_comb begin
    if (hit_rx) begin
      rd_word = rx_data_in;
    end else if (hit_rxs) begin
      rd_word = rx_status_in;
    end else if (hit_txs) begin
      rd_word = tx_status_in;
    end else if (addr_in == ADDR_RX_LEVEL) begin
      rd_word = rx_fifo_level_info_in;
    end else if (addr_in == ADDR_TX_LEVEL) begin
      rd_word = tx_fifo_level_info_in;
    end else if (hit_cnt) begin
      rd_word = cnt_word;
    end else if (addr_in == ADDR_ENDIAN) begin
      rd_word = ENDIAN_WORD;
    end else begin
      rd_word = UNMAPPED_WORD;
    end
  end

  always_comb begin
    cyc_d = cyc_q;
    case (cyc_q)
      CYC_IDLE: begin
        if (rd_active) begin
          cyc_d = CYC_READ;
        end else if (wr_active) begin
          cyc_d = CYC_WRITE;
        end
      end
      CYC_READ: begin
        if (!rd_active) begin
          cyc_d = CYC_IDLE;
        end
      end
      CYC_WRITE: begin
        if (!wr_active) begin
          cyc_d = CYC_IDLE;
        end
      end
      default: cyc_d = CYC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_q <= CYC_IDLE;
      addr_q <= '0;
      burst_cnt_q <= 5'h00;
    end else begin
      cyc_q <= cyc_d;
      if (read_take || wr_active) begin
        addr_q <= addr_in;
      end
      if (rd_start) begin
        burst_cnt_q <= 5'h01;
      end else if (do_read && burst_cnt_q != 5'h1F) begin
        burst_cnt_q <= burst_cnt_q + 5'h01;
      end
    end
  end

  // =========================================
  // Read data path
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_q <= '0;
      oe_q <= 1'b0;
      count_hold_q <= '0;
      rx_pop_q <= 1'b0;
      rxs_pop_q <= 1'b0;
      txs_pop_q <= 1'b0;
    end else begin
      oe_q <= rd_active && !rd_end;
      if (rd_start) begin
        count_hold_q <= drop_count_in;
      end
      if (do_read) begin
        data_q <= rd_word;
      end
      rx_pop_q <= do_read && hit_rx;
      rxs_pop_q <= do_read && hit_rxs;
      txs_pop_q <= do_read && hit_txs;
    end
  end

  // =========================================
  // Write path
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wdata_q <= '0;
      wsel_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_addr_q <= '0;
      reg_data_q <= '0;
      lane_q <= '0;
    end else begin
      if (wr_active) begin
        wdata_q <= data_in;
        wsel_q <= fifo_sel_in;
      end
      reg_wr_q <= wr_end && !wsel_q;
      if (wr_end && !wsel_q) begin
        reg_addr_q <= addr_q;
        reg_data_q <= wdata_q;
      end
      if (do_read || wr_start) begin
        lane_q <= eff_addr[SEL_W-1:0];
      end
    end
  end

  // Direct writes go to the transmit buffer
  word_buffer u_tx_buf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .fill_data_in(wdata_q),
    .fill_valid_in(wr_end && wsel_q),
    .fill_ready_out(),
    .drain_data_out(tx_data_out),
    .drain_valid_out(buf_valid),
    .drain_ready_in(tx_data_ready_in)
  );

  assign data_out = data_q;
  assign data_oe_out = oe_q;
  assign rx_data_pop_out = rx_pop_q;
  assign rx_status_pop_out = rxs_pop_q;
  assign tx_status_pop_out = txs_pop_q;
  assign tx_data_valid_out = buf_valid;
  assign reg_wr_addr_out = reg_addr_q;
  assign reg_wr_data_out = reg_data_q;
  assign reg_wr_out = reg_wr_q;
  assign fifo_lane_out = lane_q;

  // =========================================
  // Checks
  sequence s_write_ends;
    (cyc_q == CYC_WRITE) ##1 (cyc_q == CYC_IDLE);
  endsequence

  AST_READ_START: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_start |=> oe_q) else $error("read did not enable data bus");
  AST_OE_OFF: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !rd_active |=> !oe_q) else $error("data bus driven outside read");
  AST_RX_DIRECT: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (do_read && fifo_sel_in) |=> rx_pop_q && data_q == $past(rx_data_in))
    else $error("direct read did not return receive word");
  AST_DIRECT_WR: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_write_ends |-> reg_wr_q == !$past(wsel_q)) else $error("direct write hit register");
  AST_REG_WR: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_end && !wsel_q) |=> reg_wr_q && reg_data_q == $past(wdata_q))
    else $error("register write lost");
  AST_BURST_LIMIT: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (read_take && !fifo_sel_in && burst_cnt_q >= BURST_MAX) |=>
    $stable(data_q) && !rx_pop_q && !rxs_pop_q && !txs_pop_q)
    else $error("ordinary burst exceeded limit");
  AST_LANE: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (do_read && fifo_sel_in) |=> lane_q == $past(addr_in[1:0])) else $error("lane bits lost");
  AST_WR_ONCE: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reg_wr_q |=> !reg_wr_q) else $error("register write repeated");
endmodule

// ===== host_port_pkg.sv
// Shared constants for the SRAM-like host bus port.
// Assumes a single 25 MHz core clock and pins already synchronous to it.
package host_port_pkg;
  // =========================================
  // Widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int SEL_W = 2;
  // =========================================
  // Address decode: word address A[7:1]
  localparam logic [6:0] ADDR_RX_DATA = 7'h00;
  localparam logic [6:0] ADDR_RX_STATUS = 7'h20;
  localparam logic [6:0] ADDR_TX_STATUS = 7'h24;
  localparam logic [6:0] ADDR_RX_LEVEL = 7'h3E;
  localparam logic [6:0] ADDR_TX_LEVEL = 7'h40;
  localparam logic [6:0] ADDR_DROP_CNT = 7'h50;
  localparam logic [6:0] ADDR_ENDIAN = 7'h32;
  localparam logic [15:0] ENDIAN_WORD = 16'h4321;
  localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
  // =========================================
  // Timing
  localparam int CLK_NS = 40;
  localparam int BURST_MAX_WORDS = 16;
  localparam int ADDR_HOLD_NS = 45;
  localparam int ADDR_DATA_NS = 40;
  localparam int ADDR_DATA_CYC = (ADDR_DATA_NS / CLK_NS) < 1 ? 1 : (ADDR_DATA_NS / CLK_NS);
  localparam logic [4:0] BURST_MAX = 5'h10;
  // =========================================
  // Cycle kinds
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } cyc_t;
endpackage

// ===== word_buffer.sv
// Two-entry valid/ready buffer for 16-bit words.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module word_buffer
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Fill side
  input wire logic [DATA_W-1:0] fill_data_in,
  input wire logic fill_valid_in,
  output logic fill_ready_out,
  // Drain side
  output logic [DATA_W-1:0] drain_data_out,
  output logic drain_valid_out,
  input wire logic drain_ready_in
);
  logic [DATA_W-1:0] head_q;
  logic [DATA_W-1:0] spare_q;
  logic head_v_q;
  logic spare_v_q;
  // Head register feeds the drain side, spare absorbs a stall
  wire head_free = !head_v_q || drain_ready_in;
  wire take = fill_valid_in && !spare_v_q;
  wire head_load = head_free && (spare_v_q || take);
  wire spare_load = !head_free && take;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      head_v_q <= 1'b0;
      spare_v_q <= 1'b0;
    end else begin
      if (head_free) begin
        head_v_q <= spare_v_q || take;
        spare_v_q <= 1'b0;
      end else if (take) begin
        spare_v_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (head_load) begin
      head_q <= spare_v_q ? spare_q : fill_data_in;
    end
    if (spare_load) begin
      spare_q <= fill_data_in;
    end
  end

  assign fill_ready_out = !spare_v_q;
  assign drain_valid_out = head_v_q;
  assign drain_data_out = head_q;
endmodule

// ===== host_model.sv
// Host model: strobes, address, direct select and write data.
// Assumes the caller steps it from the core clock.
`timescale 1ns/1ps
module host_model
  import host_port_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Strobes and address
  output logic host_select_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic fifo_sel_out,
  // Write data
  output logic [DATA_W-1:0] data_out
);
  initial begin
    host_select_n_out = 1'b1;
    read_strobe_n_out = 1'b1;
    write_strobe_n_out = 1'b1;
    addr_out = '0;
    fifo_sel_out = 1'b0;
    data_out = 16'h0000;
  end
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  // Direct select moves with the address
  task automatic move(input logic [ADDR_W-1:0] a, input logic s);
    addr_out = a;
    fifo_sel_out = s;
  endtask
  task automatic rd_go(input logic [ADDR_W-1:0] a, input logic s);
    step();
    move(a, s);
    host_select_n_out = 1'b0;
    read_strobe_n_out = 1'b0;
  endtask
  // Two idle cycles end a read; longer waits are the caller's
  task automatic rd_end(input logic by_sel);
    if (by_sel) begin
      host_select_n_out = 1'b1;
    end else begin
      read_strobe_n_out = 1'b1;
    end
    step();
    host_select_n_out = 1'b1;
    read_strobe_n_out = 1'b1;
    step();
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic s, input logic [DATA_W-1:0] d);
    step();
    move(a, s);
    data_out = d;
    host_select_n_out = 1'b0;
    write_strobe_n_out = 1'b0;
    step();
    write_strobe_n_out = 1'b1;
    host_select_n_out = 1'b1;
    step();
    data_out = ~d;
  endtask
endmodule

// ===== testbench.sv
// Testbench: host reads, bursts, direct FIFO access and writes.
// Assumes the host port with its two-entry transmit buffer.
`timescale 1ns/1ps
module testbench;
  import host_port_pkg::*;
  localparam logic [DATA_W-1:0] RXS = 16'h5A01;
  localparam logic [DATA_W-1:0] TXS = 16'h5A02;
  localparam logic [DATA_W-1:0] RXL = 16'h0C03;
  localparam logic [DATA_W-1:0] TXL = 16'h0C04;
  localparam logic [DATA_W-1:0] DRP = 16'h0D05;
  logic clk_in, nrst_in, sel_n, rd_n, wr_n, fsel, oe, rx_pop, rxs_pop, txs_pop;
  logic tx_v, tx_rdy, reg_wr;
  logic [ADDR_W-1:0] addr, reg_a;
  logic [DATA_W-1:0] hdata, rdata, rx_word, tx_d, reg_d;
  logic [SEL_W-1:0] lane;
  int rx_pops = 0;
  int st_pops = 0;
  int bad_count = 0;
  int checks = 0;
  assign rx_word = 16'hA000 + rx_pops[15:0];
  always @(posedge clk_in) begin
    rx_pops <= rx_pops + (rx_pop === 1'b1);
    st_pops <= st_pops + (rxs_pop === 1'b1) + (txs_pop === 1'b1);
  end
  host_model host_u (.clk_in(clk_in), .host_select_n_out(sel_n), .read_strobe_n_out(rd_n),
    .write_strobe_n_out(wr_n), .addr_out(addr), .fifo_sel_out(fsel), .data_out(hdata));
  sram_like_host_bus_port dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .host_select_n_in(sel_n), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .addr_in(addr), .fifo_sel_in(fsel), .data_in(hdata), .data_out(rdata),
    .data_oe_out(oe), .rx_data_in(rx_word), .rx_data_pop_out(rx_pop),
    .rx_status_in(RXS), .rx_status_pop_out(rxs_pop), .tx_status_in(TXS),
    .tx_status_pop_out(txs_pop), .rx_fifo_level_info_in(RXL),
    .tx_fifo_level_info_in(TXL), .drop_count_in(DRP), .tx_data_out(tx_d),
    .tx_data_valid_out(tx_v), .tx_data_ready_in(tx_rdy), .reg_wr_addr_out(reg_a),
    .reg_wr_data_out(reg_d), .reg_wr_out(reg_wr), .fifo_lane_out(lane));
  task automatic cmp16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_regs();
    logic [ADDR_W-1:0] a [7];
    logic [DATA_W-1:0] e [7];
    int p;
    a = '{ADDR_ENDIAN, ADDR_RX_LEVEL, ADDR_TX_LEVEL, ADDR_DROP_CNT, ADDR_RX_STATUS,
      ADDR_TX_STATUS, 7'h11};
    e = '{ENDIAN_WORD, RXL, TXL, DRP, RXS, TXS, UNMAPPED_WORD};
    for (int i = 0; i < 7; i++) begin
      p = st_pops;
      host_u.rd_go(a[i], 1'b0);
      host_u.step();
      host_u.step();
      cmp16(rdata, e[i]);
      cmp1(oe, 1'b1);
      host_u.rd_end(i[0]);
      cmp1(oe, 1'b0);
      cmp1(st_pops == p + (i == 4 || i == 5), 1'b1);
    end
    $display("t_regs finished");
  endtask
  task automatic t_burst();
    logic [DATA_W-1:0] e;
    host_u.rd_go(ADDR_ENDIAN, 1'b0);
    for (int k = 0; k < 20; k++) begin
      if (k > 0) host_u.move(k[0] ? ADDR_RX_LEVEL : ADDR_ENDIAN, 1'b0);
      host_u.step();
      host_u.step();
      e = (k >= BURST_MAX_WORDS || k[0]) ? RXL : ENDIAN_WORD;
      cmp16(rdata, e);
    end
    host_u.rd_end(1'b0);
    $display("t_burst finished");
  endtask
  task automatic t_direct();
    int p;
    p = rx_pops;
    host_u.rd_go(7'h7C, 1'b1);
    for (int k = 0; k < 20; k++) begin
      if (k > 0) host_u.move({k[4:0], k[1:0]}, 1'b1);
      host_u.step();
      host_u.step();
      cmp16(rdata, 16'hA000 + p[15:0] + k[15:0]);
      cmp1(lane == k[1:0], 1'b1);
    end
    host_u.rd_end(1'b1);
    cmp1(rx_pops == p + 20, 1'b1);
    $display("t_direct finished");
  endtask
  task automatic t_write();
    tx_rdy = 1'b0;
    host_u.wr(7'h11, 1'b0, 16'h1234);
    cmp1(reg_wr, 1'b1);
    cmp16(reg_d, 16'h1234);
    cmp1(reg_a == 7'h11, 1'b1);
    for (int i = 0; i < 3; i++) host_u.wr(7'h7F - 7'(i), 1'b1, 16'hB000 + 16'(i));
    host_u.step();
    host_u.step();
    host_u.step();
    cmp1(tx_v, 1'b1);
    cmp16(tx_d, 16'hB000);
    tx_rdy = 1'b1;
    host_u.step();
    cmp16(tx_d, 16'hB001);
    host_u.step();
    cmp1(tx_v, 1'b0);
    $display("t_write finished");
  endtask
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    nrst_in = 1'b0;
    tx_rdy = 1'b1;
    repeat (10) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_regs();
    t_burst();
    t_direct();
    t_write();
    end_of_test();
  end
  // Run needs about 150 cycles
  initial begin
    #(2000 * 40);
    bad_count++;
    end_of_test();
  end
endmodule
